// *** shared/txsw_map.svh ***
`ifndef TXSW_MAP_SVH
`define TXSW_MAP_SVH
// Register byte offsets
`define TXSW_OFF_CTRL      12'h000
`define TXSW_OFF_STAT      12'h004
`define TXSW_OFF_IMASK     12'h008
`define TXSW_OFF_WORD      12'h00C
`define TXSW_OFF_TALLY     12'h010
// Status word bit positions
`define TXSW_B_OWN         31
`define TXSW_B_ERR         15
`define TXSW_B_JAB         14
`define TXSW_B_CDROP       11
`define TXSW_B_NOCAR       10
`define TXSW_B_LATE        9
`define TXSW_B_RETRY       8
`define TXSW_B_HBEAT       7
`define TXSW_B_TALLY_LO    3
`define TXSW_B_STARVE      1
`define TXSW_B_WAIT        0
// Interrupt status bit positions
`define TXSW_I_TXDONE      0
`define TXSW_I_JAB         3
`define TXSW_I_UNDER       5
// Control fields
`define TXSW_C_MODE_LO     10
`define TXSW_MODE_ILOOP    2'h1
`define TXSW_RETRY_MAX     5'h10
`define TXSW_IMASK_RST     32'h00000000
`endif

// *** shared/txsw_pkg.sv ***
package txsw_pkg;
	typedef enum logic [3:0] {
		TXSW_IDLE    = 4'h1,
		TXSW_SEND    = 4'h2,
		TXSW_STOPPED = 4'h4,
		TXSW_SUSPEND = 4'h8
	} txsw_state_t;

	// Line events from the transmit engine, one-cycle pulses except carrier, which is a level held through the frame
	typedef struct packed {
		logic start;
		logic done;
		logic emptied;
		logic collision;
		logic late;
		logic jabber;
		logic fifo_empty;
		logic carrier;
		logic defer;
		logic hb_pulse;
	} txsw_ev_t;
endpackage : txsw_pkg

// *** verilog/txsw_status.sv ***
`timescale 1ns/10ps
`include "txsw_map.svh"
////////////////////////////////////////////////////////////////////////
module txsw_status (
	input  wire logic           i_clk_sys,
	input  wire logic           i_nrst,
	input  wire logic           i_psel,
	input  wire logic           i_penable,
	input  wire logic           i_pwrite,
	input  wire logic [11:0]    i_paddr,
	input  wire logic [31:0]    i_pwdata,
	input  wire txsw_pkg::txsw_ev_t i_ev,
	input  wire logic           i_mode_10m,
	input  wire logic           i_desc_owned,
	output logic [31:0]         o_prdata,
	output logic                o_pready,
	output logic                o_pslverr,
	output logic                o_wb_valid,
	output logic [31:0]         o_wb_word,
	output logic                o_abort,
	output logic [3:0]          o_state,
	output logic                o_irq
);
	////////////////////////////////////////////////////////////////////
	// Bus decode
	logic [31:0]               ctrl_q;
	logic [31:0]               stat_q;
	logic [31:0]               imask_q;
	logic [31:0]               word_q;
	logic [31:0]               rdata_d;
	logic                      hit_ok;
	txsw_pkg::txsw_state_t     st_q;
	txsw_pkg::txsw_state_t     st_d;
	logic                      own_q;
	logic                      jab_q, cdrop_q, nocar_q, late_q, retry_q;
	logic                      hbeat_q, starve_q, wait_q, carseen_q;
	logic                      retried_q;
	logic [4:0]                coll_q;
	logic                      abort_d;
	logic                      finish;

	wire acc      = i_psel && i_penable;
	// Write lands only at the edge that sees pready high
	wire wr_en    = acc && i_pwrite && o_pready;
	wire sel_ctrl = i_paddr == `TXSW_OFF_CTRL;
	wire sel_stat = i_paddr == `TXSW_OFF_STAT;
	wire sel_mask = i_paddr == `TXSW_OFF_IMASK;
	wire sel_word = i_paddr == `TXSW_OFF_WORD;
	wire sel_tal  = i_paddr == `TXSW_OFF_TALLY;
	assign hit_ok = sel_ctrl | sel_stat | sel_mask | sel_word | sel_tal;
	wire iloop    = ctrl_q[`TXSW_C_MODE_LO +: 2] == `TXSW_MODE_ILOOP;
	wire run_req  = ctrl_q[0];
	wire sending  = st_q == txsw_pkg::TXSW_SEND;

	assign rdata_d = sel_ctrl ? ctrl_q :
		sel_stat ? stat_q :
		sel_mask ? imask_q :
		sel_word ? word_q :
		sel_tal  ? {27'h0000000, coll_q} : 32'h00000000;

	////////////////////////////////////////////////////////////////////
	// Abort causes
	wire ev_jab   = sending && i_ev.jabber;
	wire ev_starv = sending && i_ev.fifo_empty;
	wire ev_late  = sending && i_ev.late;
	wire ev_coll  = sending && i_ev.collision && !i_ev.late;
	wire coll_lim = ev_coll && (coll_q + 5'h01 == `TXSW_RETRY_MAX);
	assign abort_d  = ev_jab | ev_starv | ev_late | coll_lim;
	assign finish   = sending && (abort_d || i_ev.done || i_ev.emptied);

	// Heartbeat only checked at 10 Mb/s, first attempt, clean frame
	wire hb_chk = i_mode_10m && !retried_q && !starve_q && !ev_starv;
	wire hb_bad = hb_chk && !carseen_q && !abort_d;

	// Loopback suppresses carrier flags rather than reporting noise
	wire cd_fin = (cdrop_q | (sending && carseen_q && !i_ev.carrier)) && !iloop;
	wire nc_fin = !carseen_q && !i_ev.carrier && !iloop;
	wire lc_fin = (late_q | ev_late) && !(starve_q | ev_starv);
	wire rl_fin = retry_q | coll_lim;
	wire jb_fin = jab_q | ev_jab;
	wire uf_fin = starve_q | ev_starv;
	wire hb_fin = (hbeat_q | hb_bad) && !jb_fin;
	wire es_fin = uf_fin | rl_fin | lc_fin | nc_fin | cd_fin | jb_fin;
	wire [3:0] tal_fin = rl_fin ? 4'h0 : coll_q[3:0];

	wire [31:0] word_d = {1'b0, 15'h0000, es_fin, jb_fin, 2'h0, cd_fin, nc_fin,
		lc_fin, rl_fin, hb_fin, tal_fin, 1'b0, uf_fin, wait_q};

	////////////////////////////////////////////////////////////////////
	// Transmit process state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			txsw_pkg::TXSW_IDLE:    if (run_req && i_desc_owned && i_ev.start) st_d = txsw_pkg::TXSW_SEND;
			txsw_pkg::TXSW_SEND: begin
				if (ev_jab) st_d = txsw_pkg::TXSW_STOPPED;
				else if (ev_starv) st_d = txsw_pkg::TXSW_SUSPEND;
				else if (finish) st_d = txsw_pkg::TXSW_IDLE;
			end
			txsw_pkg::TXSW_STOPPED: if (!run_req) st_d = txsw_pkg::TXSW_IDLE;
			txsw_pkg::TXSW_SUSPEND: if (wr_en && sel_ctrl && i_pwdata[0]) st_d = txsw_pkg::TXSW_IDLE;
			default:                st_d = txsw_pkg::TXSW_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) st_q <= txsw_pkg::TXSW_IDLE;
		else st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////
	// Per-frame status accumulation
	wire new_frame = st_q == txsw_pkg::TXSW_IDLE && st_d == txsw_pkg::TXSW_SEND;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			{jab_q, cdrop_q, nocar_q, late_q, retry_q, hbeat_q, starve_q, wait_q} <= 8'h00;
			carseen_q <= 1'b0;
			retried_q <= 1'b0;
			coll_q    <= 5'h00;
			own_q     <= 1'b0;
		end else if (new_frame) begin
			{jab_q, cdrop_q, nocar_q, late_q, retry_q, hbeat_q, starve_q, wait_q} <= 8'h00;
			carseen_q <= i_ev.carrier;
			retried_q <= 1'b0;
			coll_q    <= 5'h00;
			own_q     <= 1'b1;
		end else if (sending) begin
			if (i_ev.carrier) carseen_q <= 1'b1;
			if (carseen_q && !i_ev.carrier) cdrop_q <= 1'b1;
			if (i_ev.defer) wait_q <= 1'b1;
			if (ev_coll && !coll_lim) begin
				coll_q    <= coll_q + 5'h01;
				retried_q <= 1'b1;
			end
			if (coll_lim) retry_q <= 1'b1;
			if (ev_late) late_q <= 1'b1;
			if (ev_jab) jab_q <= 1'b1;
			if (ev_starv) starve_q <= 1'b1;
			if (finish) own_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers, write-back and interrupts
	wire [31:0] ev_bits = {26'h0000000, sending && ev_starv, 1'b0, ev_jab, 2'h0,
		finish && !ev_jab};

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q     <= 32'h00000000;
			stat_q     <= 32'h00000000;
			imask_q    <= `TXSW_IMASK_RST;
			word_q     <= 32'h00000000;
			o_wb_valid <= 1'b0;
			o_wb_word  <= 32'h00000000;
			o_abort    <= 1'b0;
			o_prdata   <= 32'h00000000;
			o_pready   <= 1'b0;
			o_pslverr  <= 1'b0;
			o_irq      <= 1'b0;
		end else begin
			if (wr_en && sel_ctrl) ctrl_q <= i_pwdata;
			if (wr_en && sel_mask) imask_q <= i_pwdata;
			// Hardware set wins over a same-cycle write-one clear
			stat_q   <= (stat_q & ~((wr_en && sel_stat) ? i_pwdata : 32'h00000000)) | ev_bits;
			o_wb_valid <= finish;
			o_wb_word  <= word_d;
			if (finish) word_q <= word_d;
			o_abort  <= abort_d;
			// Answer after the first access edge, data stands with pready
			o_prdata <= (acc && !i_pwrite && !o_pready) ? rdata_d : 32'h00000000;
			o_pready <= acc && !o_pready;
			o_pslverr <= acc && !o_pready && !hit_ok;
			o_irq    <= |(((stat_q & ~((wr_en && sel_stat) ? i_pwdata : 32'h00000000)) | ev_bits) & imask_q);
		end
	end

	assign o_state = st_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_jab_ev;
		sending && i_ev.jabber;
	endsequence

	a_jab_stops: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_jab_ev |=> st_q == txsw_pkg::TXSW_STOPPED && stat_q[`TXSW_I_JAB])
		else $error("jabber did not stop process");
	a_starve_susp: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ev_starv && !ev_jab |=> st_q == txsw_pkg::TXSW_SUSPEND && stat_q[`TXSW_I_UNDER] && stat_q[`TXSW_I_TXDONE])
		else $error("underflow did not suspend");
	a_wb_own_clr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish |=> o_wb_valid && !o_wb_word[`TXSW_B_OWN])
		else $error("write-back missing");
	a_err_sum: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_valid |-> o_wb_word[`TXSW_B_ERR] == (o_wb_word[`TXSW_B_STARVE] | o_wb_word[`TXSW_B_RETRY] |
		o_wb_word[`TXSW_B_LATE] | o_wb_word[`TXSW_B_NOCAR] | o_wb_word[`TXSW_B_CDROP] | o_wb_word[`TXSW_B_JAB]))
		else $error("error summary mismatch");
	a_hb_jab: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_valid && o_wb_word[`TXSW_B_JAB] |-> !o_wb_word[`TXSW_B_HBEAT])
		else $error("heartbeat with jabber");
	a_loop_carr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish && iloop |=> !o_wb_word[`TXSW_B_CDROP] && !o_wb_word[`TXSW_B_NOCAR])
		else $error("carrier flag in loopback");
	a_late_uf: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_valid && o_wb_word[`TXSW_B_STARVE] |-> !o_wb_word[`TXSW_B_LATE])
		else $error("late collision with underflow");
	a_retry_lim: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		coll_lim |=> o_abort && o_wb_word[`TXSW_B_RETRY] && o_wb_word[6:3] == 4'h0)
		else $error("retry limit not flagged");
	a_hb_retry: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish && (retried_q || !i_mode_10m) |=> !o_wb_word[`TXSW_B_HBEAT])
		else $error("heartbeat set on retry");

	////////////////////////////////////////////////////////////////////
	// Ownership and write-back
	sequence s_frame_close;
		finish;
	endsequence

	sequence s_wb_out;
		o_wb_valid && !o_wb_word[`TXSW_B_OWN];
	endsequence

	// Controller holds the descriptor for the whole frame
	a_own_held: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		sending |-> own_q)
		else $error("ownership lost mid-frame");

	// A frame only starts on a descriptor handed over by the host
	a_own_start: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		new_frame |-> i_desc_owned && run_req)
		else $error("frame started without ownership");

	// Ownership goes back at the close of every frame
	a_own_release: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_frame_close |=> !own_q)
		else $error("ownership not released");

	// Status and release travel in one write
	a_wb_status: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_frame_close |=> s_wb_out)
		else $error("status not written with release");

	// One write per frame, never a repeat
	a_wb_single: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_valid |=> !o_wb_valid)
		else $error("double write-back");

	////////////////////////////////////////////////////////////////////
	// Abort causes
	a_jab_abort: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		s_jab_ev |=> o_abort && o_wb_word[`TXSW_B_JAB])
		else $error("jabber did not abort");

	// Late collision masked by starvation, so only check clean cases
	a_late_abort: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ev_late && !uf_fin |=> o_abort && o_wb_word[`TXSW_B_LATE])
		else $error("late collision not flagged");

	a_uf_abort: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		ev_starv |=> o_abort && o_wb_word[`TXSW_B_STARVE])
		else $error("underflow not flagged");

	// Stopped stays stopped until software drops run
	a_stop_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		st_q == txsw_pkg::TXSW_STOPPED && run_req |=> st_q == txsw_pkg::TXSW_STOPPED)
		else $error("left stopped state early");

	// Suspend waits for a run write
	a_susp_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		st_q == txsw_pkg::TXSW_SUSPEND && !(wr_en && sel_ctrl && i_pwdata[0]) |=>
		st_q == txsw_pkg::TXSW_SUSPEND)
		else $error("left suspend early");

	a_state_hot: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$onehot(st_q))
		else $error("state not one-hot");

	////////////////////////////////////////////////////////////////////
	// Status flags
	a_nc_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish && !carseen_q && !i_ev.carrier && !iloop |=> o_wb_word[`TXSW_B_NOCAR])
		else $error("missing carrier not flagged");

	a_cd_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish && cdrop_q && !iloop |=> o_wb_word[`TXSW_B_CDROP])
		else $error("carrier drop not flagged");

	// Heartbeat means nothing at the fast rate
	a_hb_speed: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		finish && !i_mode_10m |=> !o_wb_word[`TXSW_B_HBEAT])
		else $error("heartbeat at fast rate");

	a_hb_uf: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_wb_valid && o_wb_word[`TXSW_B_STARVE] |-> !o_wb_word[`TXSW_B_HBEAT])
		else $error("heartbeat with underflow");

	a_wait_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		sending && i_ev.defer |=> wait_q)
		else $error("deferral not recorded");

	// Tally is four bits wide, the counter never passes fifteen
	a_tally_range: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		coll_q[4] == 1'b0)
		else $error("tally overflow");

	////////////////////////////////////////////////////////////////////
	// Bus and interrupt
	a_pready_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_pready |=> !o_pready)
		else $error("pready longer than one cycle");

	a_pslverr_with: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_pslverr |-> o_pready)
		else $error("pslverr without pready");

	// Irq follows the mask of the cycle before
	a_irq_mask: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$past(imask_q) == 32'h00000000 |-> !o_irq)
		else $error("irq with all masked");
endmodule : txsw_status

// *** verif/txsw_host.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Host driver side: hands out one descriptor at a time, takes status back
module txsw_host (
	input  wire logic        i_clk_sys,
	input  wire logic        i_wb_valid,
	input  wire logic [31:0] i_wb_word,
	output logic             o_owned
);
	logic [31:0] mem_q;
	initial o_owned = 1'b0;
	// Host touches the word only after ownership came back
	always @(posedge i_clk_sys) begin
		if (i_wb_valid) begin
			mem_q   <= i_wb_word;
			o_owned <= 1'b0;
		end
	end
	// One descriptor per frame, so first one is set last trivially
	// Single aligned word, no address offsets modelled
	task give;
		@(posedge i_clk_sys);
		o_owned <= 1'b1;
	endtask : give
endmodule : txsw_host

// *** verif/tx_descriptor_status_writeback_tb_top.sv ***
`timescale 1ns/10ps
`include "txsw_map.svh"
module tx_descriptor_status_writeback_tb_top;
	logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, m10 = 0;
	logic [11:0] pa = '0;
	logic [31:0] pwd = '0, prd, wbw, r;
	logic [9:0]  ev = '0;
	logic        pready, perr, wbv, abort, irq, owned, e;
	logic [3:0]  st;
	int          fail_count = 0, tests_run = 0, cyc = 0;
	logic [31:0] exq[$], mkq[$];
	always #4 clk = ~clk;
	txsw_host u_host (.i_clk_sys(clk), .i_wb_valid(wbv), .i_wb_word(wbw), .o_owned(owned));
	txsw_status DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(pa), .i_pwdata(pwd), .i_ev(txsw_pkg::txsw_ev_t'(ev)), .i_mode_10m(m10),
		.i_desc_owned(owned), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr), .o_wb_valid(wbv),
		.o_wb_word(wbw), .o_abort(abort), .o_state(st), .o_irq(irq));
////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task report_and_stop;
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task pulse(input logic [9:0] m);
		@(posedge clk); ev <= ev | m;
		@(posedge clk); ev <= ev & 10'h004;
	endtask : pulse
////////////////////////////////////////////////////////////////////////
	// Queue drained by whatever the device writes back
	always @(negedge clk) begin
		if (wbv === 1'b1) begin
			if (exq.size() == 0) chk("spurious wb", 32'h1, 32'h0);
			else begin
				chk("wb word", wbw & mkq.pop_front(), exq.pop_front());
			end
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		int          k;
		// Error table: late, jabber, underflow, excess collisions abort; no carrier ends on done
		logic [9:0]  cz[5] = '{10'h020, 10'h010, 10'h008, 10'h040, 10'h100};
		logic [31:0] xw[5] = '{32'h8200, 32'hC000, 32'h8002, 32'h8100, 32'h8400};
		// Heartbeat and tally masked where they carry no meaning
		logic [31:0] xm[5] = '{32'hFFFFFFFF, 32'hFFFFFF7F, 32'hFFFFFF7F, 32'hFFFFFF87, 32'hFFFFFFFF};
		logic [3:0]  xs[5] = '{4'h0, 4'h4, 4'h8, 4'h0, 4'h0};
		logic [31:0] xi[5] = '{32'h0, 32'h8, 32'h21, 32'h0, 32'h0};
		void'($urandom(4254));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, `TXSW_OFF_IMASK, 32'h0);
		chk("imask reset", r, `TXSW_IMASK_RST);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		apb(1'b1, `TXSW_OFF_IMASK, 32'h20);
		apb(1'b1, `TXSW_OFF_CTRL, 32'h1);
		// Clean 10 Mb/s frame: deferral, random retries, carrier seen
		k = 1 + $urandom % 15;
		m10 <= 1'b1;
		u_host.give();
		pulse(10'h200);
		@(posedge clk); ev[2] <= 1'b1;
		pulse(10'h002);
		exq.push_back(32'h1 | (k << 3));
		mkq.push_back(32'hFFFFFFFF);
		repeat (k) pulse(10'h040);
		pulse(10'h100);
		repeat (3) @(posedge clk);
		ev[2] <= 1'b0;
		m10 <= 1'b0;
		apb(1'b0, `TXSW_OFF_TALLY, 32'h0);
		chk("tally", r, k);
		for (int i = 0; i < 5; i++) begin
			u_host.give();
			pulse(10'h200);
			if (i != 4) begin
				@(posedge clk); ev[2] <= 1'b1;
			end
			exq.push_back(xw[i]);
			mkq.push_back(xm[i]);
			if (i == 3) repeat (16) pulse(10'h040);
			else pulse(cz[i]);
			repeat (3) @(posedge clk);
			ev[2] <= 1'b0;
			if (xs[i] != 4'h0) begin
				chk("state", st, xs[i]);
				apb(1'b0, `TXSW_OFF_STAT, 32'h0);
				chk("int status", r & xi[i], xi[i]);
			end
			if (i == 2) chk("irq set", irq, 1'b1);
			apb(1'b1, `TXSW_OFF_STAT, 32'h29);
			@(negedge clk);
			chk("irq clear", irq, 1'b0);
			apb(1'b1, `TXSW_OFF_CTRL, 32'h0);
			apb(1'b1, `TXSW_OFF_CTRL, 32'h1);
		end
		// Loopback at 10 Mb/s, no carrier, buffers emptied
		apb(1'b1, `TXSW_OFF_CTRL, 32'h401);
		m10 <= 1'b1;
		u_host.give();
		pulse(10'h200);
		exq.push_back(32'h80);
		mkq.push_back(32'hFFFFFFFF);
		pulse(10'h080);
		repeat (3) @(posedge clk);
		m10 <= 1'b0;
		chk("queue empty", exq.size(), 32'h0);
		report_and_stop();
	end
endmodule : tx_descriptor_status_writeback_tb_top
